// *** hw/sadp_decode.v ***
// System address decoder with power-fail interrupt source.
// Assumes a host bus clocked by core_clk_in with valid strobes.
// What this block does
// - Physical address is 24 bits, 16 MB, driven to expansion bus.
// - Onboard DRAM decode ceiling is 32 MB, but the 24-bit address reaches only 16 MB.
// - Memory 000000h-09FFFFh selects onboard DRAM.
// - 0A0000h-0BFFFFh left to video RAM, split graphics/mono/colour.
// - 0C0000h-0CFFFFh is expansion ROM, or shadow DRAM when enabled.
// - 0D0000h-0EFFFFh selects byte-wide sockets if enabled, else free.
// - 0F0000h-0FFFFFh selects BIOS ROM.
// - FF0000h-FFFFFFh aliases the same BIOS contents.
// - 100000h-FDFFFFh decodes as extended memory.
// - Ports 3F8h-3FFh primary serial, 2F8h-2FFh secondary serial.
// - Floppy registers at 3F2h, 3F4h, 3F5h and 3F7h.
// - Ports 378h-37Fh primary printer, 278h-27Fh secondary printer.
// - Display ranges 3D0h colour, 3C0h graphics, 3B0h mono.
// - DMA 1 at 00h-0Fh, DMA 2 at C0h-DFh, pages at 80h-9Fh.
// - Interrupt controllers at 20h-21h and A0h-A1h.
// - Port 92h selects fast A20 gate and reset control.
// - Ports 70h-71h select real-time clock with interrupt mask.
// - Keyboard controller 60h-64h, interval timer 40h-43h.
// - Jumper fitted and 5 V rail low raises non-maskable interrupt.
// - Power-fail indication lasts only 200 microseconds.
// - Power-fail status readable on keyboard controller input port.
`timescale 1ns/1ps
`include "sadp_defines.vh"

module sadp_decode #(
  parameter HOLD_CYCLES = `SADP_PF_US * (`SADP_CLK_HZ / 1000000),
  parameter DRAM_MB = `SADP_DRAM_MAX_MB
) (
  // Clock and reset
  input wire core_clk_in,
  input wire nrst_in,
  // Host bus
  input wire [31:0] addr_in,
  input wire mem_cycle_in,
  input wire io_cycle_in,
  // Configuration
  input wire shadow_enable_in,
  input wire socket_enable_in,
  // Power monitor pins
  input wire power_fail_enable_jumper_in,
  input wire supply_low_in,
  // Memory selects
  output reg [23:0] exp_addr_out,
  output reg dram_sel_out,
  output reg vga_ram_sel_out,
  output reg mono_ram_sel_out,
  output reg ctxt_ram_sel_out,
  output reg exp_rom_sel_out,
  output reg bytewide_socket_zero_sel_out,
  output reg bytewide_socket_one_sel_out,
  output reg bytewide_socket_two_sel_out,
  output reg bios_sel_out,
  output reg ext_mem_sel_out,
  output reg exp_mem_sel_out,
  // I/O selects
  output reg ser1_sel_out,
  output reg ser2_sel_out,
  output reg [3:0] floppy_controller_sel_out,
  output reg par1_sel_out,
  output reg par2_sel_out,
  output reg ctxt_io_sel_out,
  output reg vga_io_sel_out,
  output reg mono_io_sel_out,
  output reg dma1_sel_out,
  output reg dma2_sel_out,
  output reg dma_page_sel_out,
  output reg pic1_sel_out,
  output reg pic2_sel_out,
  output reg a20_sel_out,
  output reg rtc_sel_out,
  output reg kbc_sel_out,
  output reg pit_sel_out,
  output reg io_unclaimed_out,
  // Power fail
  output reg nmi_out,
  output reg [7:0] kbc_input_port_out
);

  function in_rng;
    input [23:0] a;
    input [23:0] lo;
    input [23:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // Aligned port block match on a 16-bit I/O address
  function io_blk;
    input [15:0] a;
    input [15:0] base;
    input [15:0] mask;
    begin
      io_blk = ((a & ~mask) == base);
    end
  endfunction

  // Pins are asynchronous to the core clock
  reg jmp_s1_reg;
  reg jmp_s2_reg;
  reg low_s1_reg;
  reg low_s2_reg;
  wire pf_active;

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      jmp_s1_reg <= 1'b0;
      jmp_s2_reg <= 1'b0;
      low_s1_reg <= 1'b0;
      low_s2_reg <= 1'b0;
    end else begin
      jmp_s1_reg <= power_fail_enable_jumper_in;
      jmp_s2_reg <= jmp_s1_reg;
      low_s1_reg <= supply_low_in;
      low_s2_reg <= low_s1_reg;
    end
  end

  sadp_pfail #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_pfail (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .enable_in(jmp_s2_reg),
    .low_in(low_s2_reg),
    .active_out(pf_active)
  );

  // Upper address bits beyond 24 are ignored by the decode
  wire [23:0] ma = addr_in[23:0];
  wire [15:0] ia = addr_in[15:0];

  // DRAM top within the 32 MB ceiling; only the first 640K is mapped low
  localparam [31:0] DRAM_BYTES = DRAM_MB * 32'h00100000;

  reg m_dram;
  reg m_vga;
  reg m_mono;
  reg m_ctxt;
  reg m_xrom;
  reg m_shadow;
  reg m_s0;
  reg m_s1;
  reg m_s2;
  reg m_bios;
  reg m_ext;

  always @* begin
    m_dram = mem_cycle_in && in_rng(ma, `SADP_DRAM_LO, `SADP_DRAM_HI);
    m_vga = mem_cycle_in && in_rng(ma, `SADP_VGA_LO, `SADP_VGA_HI);
    m_mono = mem_cycle_in && in_rng(ma, `SADP_MONO_LO, `SADP_MONO_HI);
    m_ctxt = mem_cycle_in && in_rng(ma, `SADP_CTXT_LO, `SADP_CTXT_HI);
    m_xrom = mem_cycle_in && in_rng(ma, `SADP_XROM_LO, `SADP_XROM_HI) &&
             !shadow_enable_in;
    m_shadow = mem_cycle_in && in_rng(ma, `SADP_XROM_LO, `SADP_XROM_HI) &&
               shadow_enable_in;
    m_s0 = mem_cycle_in && socket_enable_in &&
           in_rng(ma, `SADP_SOCK0_LO, `SADP_SOCK1_LO - 24'h000001);
    m_s1 = mem_cycle_in && socket_enable_in &&
           in_rng(ma, `SADP_SOCK1_LO, `SADP_SOCK2_LO - 24'h000001);
    m_s2 = mem_cycle_in && socket_enable_in &&
           in_rng(ma, `SADP_SOCK2_LO, `SADP_SOCK_HI);
    m_bios = mem_cycle_in &&
             (in_rng(ma, `SADP_BIOS_LO, `SADP_BIOS_HI) ||
              (ma >= `SADP_MIRR_LO));
    m_ext = mem_cycle_in && in_rng(ma, `SADP_EXT_LO, `SADP_EXT_HI) &&
            ({8'h00, ma} < DRAM_BYTES);
  end

  reg i_ser1;
  reg i_ser2;
  reg [3:0] i_fdc;
  reg i_par1;
  reg i_par2;
  reg i_ctxt;
  reg i_vga;
  reg i_mono;
  reg i_dma1;
  reg i_dma2;
  reg i_page;
  reg i_pic1;
  reg i_pic2;
  reg i_a20;
  reg i_rtc;
  reg i_kbc;
  reg i_pit;

  always @* begin
    i_ser1 = io_cycle_in && io_blk(ia, `SADP_IO_COM1, 16'h0007);
    i_ser2 = io_cycle_in && io_blk(ia, `SADP_IO_COM2, 16'h0007);
    i_fdc[0] = io_cycle_in && (ia == `SADP_IO_FDOR);
    i_fdc[1] = io_cycle_in && (ia == `SADP_IO_FMSR);
    i_fdc[2] = io_cycle_in && (ia == `SADP_IO_FDAT);
    i_fdc[3] = io_cycle_in && (ia == `SADP_IO_FCTL);
    i_par1 = io_cycle_in && io_blk(ia, `SADP_IO_LPT1, 16'h0007);
    i_par2 = io_cycle_in && io_blk(ia, `SADP_IO_LPT2, 16'h0007);
    i_ctxt = io_cycle_in && io_blk(ia, `SADP_IO_CTXT, 16'h000f);
    i_vga = io_cycle_in && io_blk(ia, `SADP_IO_VGA, 16'h000f);
    i_mono = io_cycle_in && io_blk(ia, `SADP_IO_MONO, 16'h000f);
    i_dma1 = io_cycle_in && io_blk(ia, `SADP_IO_DMA1, 16'h000f);
    i_dma2 = io_cycle_in && io_blk(ia, `SADP_IO_DMA2, 16'h001f);
    // Port 92h sits inside the page block; the A20 select takes it
    i_a20 = io_cycle_in && (ia == `SADP_IO_A20);
    i_page = io_cycle_in && io_blk(ia, `SADP_IO_PAGE, 16'h001f) &&
             !i_a20;
    i_pic1 = io_cycle_in && io_blk(ia, `SADP_IO_PIC1, 16'h0001);
    i_pic2 = io_cycle_in && io_blk(ia, `SADP_IO_PIC2, 16'h0001);
    i_rtc = io_cycle_in && io_blk(ia, `SADP_IO_RTC, 16'h0001);
    i_kbc = io_cycle_in && (ia >= `SADP_IO_KBC) &&
            (ia <= `SADP_IO_KBC_HI);
    i_pit = io_cycle_in && io_blk(ia, `SADP_IO_PIT, 16'h0003);
  end

  // Reserved and unlisted ports select nothing; flagged only
  wire io_any = i_ser1 | i_ser2 | (|i_fdc) | i_par1 | i_par2 | i_ctxt |
                i_vga | i_mono | i_dma1 | i_dma2 | i_page | i_pic1 |
                i_pic2 | i_a20 | i_rtc | i_kbc | i_pit;

  // Everything registered so outputs are glitch free; costs one cycle
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      exp_addr_out <= 24'h000000;
      dram_sel_out <= 1'b0;
      vga_ram_sel_out <= 1'b0;
      mono_ram_sel_out <= 1'b0;
      ctxt_ram_sel_out <= 1'b0;
      exp_rom_sel_out <= 1'b0;
      bytewide_socket_zero_sel_out <= 1'b0;
      bytewide_socket_one_sel_out <= 1'b0;
      bytewide_socket_two_sel_out <= 1'b0;
      bios_sel_out <= 1'b0;
      ext_mem_sel_out <= 1'b0;
      exp_mem_sel_out <= 1'b0;
      ser1_sel_out <= 1'b0;
      ser2_sel_out <= 1'b0;
      floppy_controller_sel_out <= 4'h0;
      par1_sel_out <= 1'b0;
      par2_sel_out <= 1'b0;
      ctxt_io_sel_out <= 1'b0;
      vga_io_sel_out <= 1'b0;
      mono_io_sel_out <= 1'b0;
      dma1_sel_out <= 1'b0;
      dma2_sel_out <= 1'b0;
      dma_page_sel_out <= 1'b0;
      pic1_sel_out <= 1'b0;
      pic2_sel_out <= 1'b0;
      a20_sel_out <= 1'b0;
      rtc_sel_out <= 1'b0;
      kbc_sel_out <= 1'b0;
      pit_sel_out <= 1'b0;
      io_unclaimed_out <= 1'b0;
      nmi_out <= 1'b0;
      kbc_input_port_out <= 8'hff;
    end else begin
      exp_addr_out <= ma;
      dram_sel_out <= m_dram | m_shadow | m_ext;
      vga_ram_sel_out <= m_vga;
      mono_ram_sel_out <= m_mono;
      ctxt_ram_sel_out <= m_ctxt;
      exp_rom_sel_out <= m_xrom;
      bytewide_socket_zero_sel_out <= m_s0;
      bytewide_socket_one_sel_out <= m_s1;
      bytewide_socket_two_sel_out <= m_s2;
      bios_sel_out <= m_bios;
      ext_mem_sel_out <= m_ext;
      // Video, expansion ROM unless shadowed, and free windows go to the expansion bus
      exp_mem_sel_out <= mem_cycle_in & ~(m_dram | m_shadow | m_ext |
                         m_s0 | m_s1 | m_s2 | m_bios);
      ser1_sel_out <= i_ser1;
      ser2_sel_out <= i_ser2;
      floppy_controller_sel_out <= i_fdc;
      par1_sel_out <= i_par1;
      par2_sel_out <= i_par2;
      ctxt_io_sel_out <= i_ctxt;
      vga_io_sel_out <= i_vga;
      mono_io_sel_out <= i_mono;
      dma1_sel_out <= i_dma1;
      dma2_sel_out <= i_dma2;
      dma_page_sel_out <= i_page;
      pic1_sel_out <= i_pic1;
      pic2_sel_out <= i_pic2;
      a20_sel_out <= i_a20;
      rtc_sel_out <= i_rtc;
      kbc_sel_out <= i_kbc;
      pit_sel_out <= i_pit;
      io_unclaimed_out <= io_cycle_in & ~io_any;
      nmi_out <= pf_active;
      // Status for the keyboard controller input port, bit 0 low active
      kbc_input_port_out <= {7'h7f, ~pf_active};
    end
  end

endmodule // sadp_decode

// *** hw/sadp_defines.vh ***
// Address ranges and timing constants for the system address decoder.
// Assumes a 40 MHz core clock; included by bare name.
`ifndef SADP_DEFINES_VH
`define SADP_DEFINES_VH

`define SADP_ADDR_W 24
`define SADP_DRAM_MAX_MB 32
`define SADP_DRAM_LO 24'h000000
`define SADP_DRAM_HI 24'h09ffff
`define SADP_VGA_LO 24'h0a0000
`define SADP_VGA_HI 24'h0affff
`define SADP_MONO_LO 24'h0b0000
`define SADP_MONO_HI 24'h0b7fff
`define SADP_CTXT_LO 24'h0b8000
`define SADP_CTXT_HI 24'h0bffff
`define SADP_XROM_LO 24'h0c0000
`define SADP_XROM_HI 24'h0cffff
`define SADP_SOCK0_LO 24'h0d0000
`define SADP_SOCK1_LO 24'h0d8000
`define SADP_SOCK2_LO 24'h0e0000
`define SADP_SOCK_HI 24'h0effff
`define SADP_BIOS_LO 24'h0f0000
`define SADP_BIOS_HI 24'h0fffff
`define SADP_EXT_LO 24'h100000
`define SADP_EXT_HI 24'hfdffff
`define SADP_MIRR_LO 24'hff0000

`define SADP_IO_COM1 16'h03f8
`define SADP_IO_COM2 16'h02f8
`define SADP_IO_FDOR 16'h03f2
`define SADP_IO_FMSR 16'h03f4
`define SADP_IO_FDAT 16'h03f5
`define SADP_IO_FCTL 16'h03f7
`define SADP_IO_LPT1 16'h0378
`define SADP_IO_LPT2 16'h0278
`define SADP_IO_CTXT 16'h03d0
`define SADP_IO_VGA 16'h03c0
`define SADP_IO_MONO 16'h03b0
`define SADP_IO_DMA1 16'h0000
`define SADP_IO_DMA2 16'h00c0
`define SADP_IO_PAGE 16'h0080
`define SADP_IO_PIC1 16'h0020
`define SADP_IO_PIC2 16'h00a0
`define SADP_IO_A20 16'h0092
`define SADP_IO_RTC 16'h0070
`define SADP_IO_KBC 16'h0060
`define SADP_IO_KBC_HI 16'h0064
`define SADP_IO_PIT 16'h0040

`define SADP_CLK_HZ 40000000
`define SADP_PF_US 200

`endif

// *** hw/sadp_pfail.v ***
// Power-fail interrupt pulse generator.
// Assumes the monitor and jumper inputs are already synchronised.
`timescale 1ns/1ps
`include "sadp_defines.vh"

module sadp_pfail #(
  parameter HOLD_CYCLES = `SADP_PF_US * (`SADP_CLK_HZ / 1000000)
) (
  input wire core_clk_in,
  input wire nrst_in,
  input wire enable_in,
  input wire low_in,
  output reg active_out
);

  reg [15:0] cnt_reg;
  reg low_d_reg;
  wire rise = low_in & ~low_d_reg & enable_in;

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg <= 16'h0000;
      low_d_reg <= 1'b0;
      active_out <= 1'b0;
    end else begin
      low_d_reg <= low_in;
      // Fixed width pulse; a long droop still gives one short pulse
      if (rise) begin
        cnt_reg <= HOLD_CYCLES[15:0] - 16'h0001;
        active_out <= 1'b1;
      end else if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end else begin
        active_out <= 1'b0;
      end
    end
  end

endmodule // sadp_pfail

// *** test/sadp_chk.sv ***
// Assertion checker for the system address decoder.
// Bound to sadp_decode; sees its ports only.
`timescale 1ns/1ps
module sadp_chk #(
  parameter HOLD_CYCLES = 8000
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Bus and pins
  input wire logic [31:0] addr_in,
  input wire logic mem_cycle_in,
  input wire logic io_cycle_in,
  input wire logic shadow_enable_in,
  input wire logic power_fail_enable_jumper_in,
  input wire logic supply_low_in,
  // Selects
  input wire logic dram_sel_out,
  input wire logic exp_rom_sel_out,
  input wire logic bios_sel_out,
  input wire logic ext_mem_sel_out,
  input wire logic a20_sel_out,
  input wire logic dma_page_sel_out,
  input wire logic nmi_out,
  input wire logic [7:0] kbc_input_port_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire [23:0] ma = addr_in[23:0];
  logic [15:0] hold_cnt_reg;
  // Counts pulse length; a restart mid-pulse would read long
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) hold_cnt_reg <= 16'h0;
    else if (nmi_out) hold_cnt_reg <= hold_cnt_reg + 16'h1;
    else hold_cnt_reg <= 16'h0;
  end
  property p_dram; mem_cycle_in && ma <= 24'h09ffff |=> dram_sel_out;
  endproperty
  a_dram: assert property (p_dram) else $error("dram select missing");
  property p_rom; mem_cycle_in && ma[23:16] == 8'h0c |=>
    exp_rom_sel_out != $past(shadow_enable_in) && dram_sel_out ==
    $past(shadow_enable_in); endproperty
  a_rom: assert property (p_rom) else $error("rom or shadow wrong");
  property p_bios; mem_cycle_in && (ma[23:16] == 8'h0f ||
    ma[23:16] == 8'hff) |=> bios_sel_out && !dram_sel_out; endproperty
  a_bios: assert property (p_bios) else $error("bios select");
  property p_ext; mem_cycle_in && ma >= 24'h100000 && ma <= 24'hfdffff
    |=> ext_mem_sel_out && !bios_sel_out; endproperty
  a_ext: assert property (p_ext) else $error("ext select missing");
  property p_a20; io_cycle_in && addr_in[15:0] == 16'h0092
    |=> a20_sel_out && !dma_page_sel_out; endproperty
  a_a20: assert property (p_a20) else $error("port 92 select");
  property p_nmi; power_fail_enable_jumper_in && !nmi_out &&
    $past(power_fail_enable_jumper_in, 3) && $rose(supply_low_in)
    |-> ##3 !nmi_out ##1 nmi_out; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi latency");
  property p_len; $fell(nmi_out) |-> hold_cnt_reg == HOLD_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("nmi pulse length");
  property p_kbc; kbc_input_port_out == {7'h7f, !nmi_out}; endproperty
  a_kbc: assert property (p_kbc) else $error("input port bit");
  c_nmi: cover property ($rose(nmi_out));
  c_rom: cover property (exp_rom_sel_out);
  c_bios: cover property (bios_sel_out);
endmodule // sadp_chk

bind sadp_decode sadp_chk #(.HOLD_CYCLES(HOLD_CYCLES)) sadp_chk_inst (
  .core_clk_in, .nrst_in, .addr_in, .mem_cycle_in, .io_cycle_in,
  .shadow_enable_in, .power_fail_enable_jumper_in, .supply_low_in,
  .dram_sel_out, .exp_rom_sel_out, .bios_sel_out, .ext_mem_sel_out,
  .a20_sel_out, .dma_page_sel_out, .nmi_out, .kbc_input_port_out
);

// *** test/sadp_host.sv ***
// Host bus model issuing memory and I/O cycles.
// Assumes a free-running clock; changes follow a rising edge.
`timescale 1ns/1ps
module sadp_host (
  // Clock
  input wire logic core_clk_in,
  // Bus to decoder
  output logic [31:0] addr_out,
  output logic mem_cycle_out,
  output logic io_cycle_out,
  output logic shadow_enable_out,
  output logic socket_enable_out
);
  initial begin
    addr_out = 32'h0;
    mem_cycle_out = 1'b0;
    io_cycle_out = 1'b0;
    shadow_enable_out = 1'b0;
    socket_enable_out = 1'b0;
  end
  // Row: io, shadow, socket, spare, address; unclaimed ports also used
  task access(input logic [59:0] r);
    @(posedge core_clk_in);
    addr_out <= {8'h00, r[55:32]};
    mem_cycle_out <= !r[59];
    io_cycle_out <= r[59];
    shadow_enable_out <= r[58];
    socket_enable_out <= r[57];
  endtask
  // Released bus shows the inverse, not a stale address
  task idle;
    @(posedge core_clk_in);
    mem_cycle_out <= 1'b0;
    io_cycle_out <= 1'b0;
    addr_out <= ~addr_out;
  endtask
endmodule // sadp_host

// *** test/testbench.sv ***
// Self-checking bench for the system address decoder.
// Assumes sadp_host drives the bus; pins come from here.
`timescale 1ns/1ps
module testbench;
  localparam HOLD = 10;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic jumper_pin = 1'b0;
  logic low_pin = 1'b0;
  wire [31:0] addr;
  wire mem_cyc, io_cyc, shd, sck, nmi;
  wire [23:0] xaddr;
  wire [7:0] kbc_port;
  wire [31:0] sel_v;
  int err_count = 0;
  int check_count = 0;
  logic [59:0] rows [0:34] = '{
    {4'h2,24'h000000,32'h80000000}, {4'h2,24'h0affff,32'h40200000},
    {4'h2,24'h0b7fff,32'h20200000}, {4'h2,24'h0b8000,32'h10200000},
    {4'h2,24'h0c0000,32'h08200000}, {4'h6,24'h0cffff,32'h80000000},
    {4'h2,24'h0d7fff,32'h04000000}, {4'h2,24'h0d8000,32'h02000000},
    {4'h2,24'h0effff,32'h01000000}, {4'h0,24'h0d0000,32'h00200000},
    {4'h2,24'h0f0000,32'h00800000}, {4'h2,24'hffffff,32'h00800000},
    {4'h2,24'h100000,32'h80400000}, {4'h2,24'hfe0000,32'h00200000},
    {4'ha,24'h0003ff,32'h00100000}, {4'ha,24'h0002f8,32'h00080000},
    {4'ha,24'h0003f2,32'h00008000}, {4'ha,24'h00037f,32'h00004000},
    {4'ha,24'h000278,32'h00002000}, {4'ha,24'h0003d0,32'h00001000},
    {4'ha,24'h0003cf,32'h00000800}, {4'ha,24'h0003b0,32'h00000400},
    {4'ha,24'h00000f,32'h00000200}, {4'ha,24'h000080,32'h00000080},
    {4'ha,24'h000092,32'h00000010}, {4'ha,24'h0000a0,32'h00000020},
    {4'ha,24'h000071,32'h00000008},
    {4'ha,24'h0003f4,32'h00010000}, {4'ha,24'h0003f5,32'h00020000},
    {4'ha,24'h0003f7,32'h00040000},
    {4'ha,24'h0000df,32'h00000100},
    {4'ha,24'h000021,32'h00000040},
    {4'ha,24'h000064,32'h00000004}, {4'ha,24'h000040,32'h00000002},
    {4'ha,24'h000200,32'h00000001}};
  always #12.5 core_clk_in = ~core_clk_in;
  sadp_host sadp_host_inst (.core_clk_in(core_clk_in), .addr_out(addr),
    .mem_cycle_out(mem_cyc), .io_cycle_out(io_cyc),
    .shadow_enable_out(shd), .socket_enable_out(sck));
  sadp_decode #(.HOLD_CYCLES(HOLD)) sadp_decode_inst (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr),
    .mem_cycle_in(mem_cyc), .io_cycle_in(io_cyc), .shadow_enable_in(shd),
    .socket_enable_in(sck), .power_fail_enable_jumper_in(jumper_pin),
    .supply_low_in(low_pin), .exp_addr_out(xaddr),
    .dram_sel_out(sel_v[31]), .vga_ram_sel_out(sel_v[30]),
    .mono_ram_sel_out(sel_v[29]), .ctxt_ram_sel_out(sel_v[28]),
    .exp_rom_sel_out(sel_v[27]), .bytewide_socket_zero_sel_out(sel_v[26]),
    .bytewide_socket_one_sel_out(sel_v[25]),
    .bytewide_socket_two_sel_out(sel_v[24]), .bios_sel_out(sel_v[23]),
    .ext_mem_sel_out(sel_v[22]), .exp_mem_sel_out(sel_v[21]),
    .ser1_sel_out(sel_v[20]), .ser2_sel_out(sel_v[19]),
    .floppy_controller_sel_out(sel_v[18:15]), .par1_sel_out(sel_v[14]),
    .par2_sel_out(sel_v[13]), .ctxt_io_sel_out(sel_v[12]),
    .vga_io_sel_out(sel_v[11]), .mono_io_sel_out(sel_v[10]),
    .dma1_sel_out(sel_v[9]), .dma2_sel_out(sel_v[8]),
    .dma_page_sel_out(sel_v[7]), .pic1_sel_out(sel_v[6]),
    .pic2_sel_out(sel_v[5]), .a20_sel_out(sel_v[4]),
    .rtc_sel_out(sel_v[3]), .kbc_sel_out(sel_v[2]), .pit_sel_out(sel_v[1]),
    .io_unclaimed_out(sel_v[0]), .nmi_out(nmi),
    .kbc_input_port_out(kbc_port));
  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    #1 chk("reset sel", 32'h0, sel_v);
    chk("reset port", 32'h000000ff, {xaddr, kbc_port});
    repeat (6) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    // Pipelined: row i is driven while row i-1 is checked
    for (int i = 0; i <= 35; i++) begin
      if (i < 35) sadp_host_inst.access(rows[i]);
      else @(posedge core_clk_in);
      #1;
      if (i > 0) chk("select", rows[i-1][31:0], sel_v);
      if (i > 0) chk("exp addr", rows[i-1][55:32], xaddr);
    end
    sadp_host_inst.idle();
    jumper_pin <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    low_pin <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    #1 chk("nmi early", 32'h0, {31'h0, nmi});
    @(posedge core_clk_in);
    #1 chk("nmi port", 32'h1fe, {23'h0, nmi, kbc_port});
    repeat (HOLD - 1) @(posedge core_clk_in);
    #1 chk("nmi held", 32'h1, {31'h0, nmi});
    @(posedge core_clk_in);
    #1 chk("nmi end", 32'h0ff, {23'h0, nmi, kbc_port});
    jumper_pin <= 1'b0;
    low_pin <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    low_pin <= 1'b1;
    repeat (12) @(posedge core_clk_in);
    #1 chk("nmi no jumper", 32'h0, {31'h0, nmi});
    // Reset in mid-run with a BIOS access held on the bus
    sadp_host_inst.access({4'h2, 24'h0f8000, 32'h0});
    @(posedge core_clk_in);
    nrst_in <= 1'b0;
    #1 chk("reset again", 32'h0, sel_v);
    @(posedge core_clk_in);
    nrst_in <= 1'b1;
    @(posedge core_clk_in);
    #1 chk("after reset", 32'h00800000, sel_v);
    give_verdict();
  end
  // Run needs about 90 cycles; generous margin
  initial begin : watchdog
    repeat (3000) @(posedge core_clk_in);
    err_count++;
    give_verdict();
  end
endmodule // testbench
